// ### inc/rwt_params.svh
`ifndef RWT_PARAMS_SVH
`define RWT_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define RWT_IDX_DLY_TIME 8'h0a
`define RWT_IDX_RSVD 8'h0b
`define RWT_IDX_FWTO 8'h0c
`define RWT_ADDR_DLY_LO ({2'h0, `RWT_IDX_DLY_TIME, 2'h0})
`define RWT_ADDR_RSVD ({2'h0, `RWT_IDX_RSVD, 2'h0})
`define RWT_ADDR_FWTO ({2'h0, `RWT_IDX_FWTO, 2'h0})
`define RWT_ADDR_DLY_HI 12'h080
`define RWT_ADDR_CTRL 12'h084
`define RWT_ADDR_STATUS 12'h088
`define RWT_ADDR_MASK 12'h08c
`define RWT_ADDR_STATE 12'h090

// Event bit positions, shared by status and mask
`define RWT_EV_TIMEOUT 0
`define RWT_EV_FRAME_READY 1
`define RWT_EV_CRC_GOOD 2
`define RWT_EV_DLY_TX 3
`define RWT_EV_DLY_RX 4
`define RWT_EV_W 5

// Delayed time handling
`define RWT_DLY_IGNORE_BITS 9
`define RWT_PSTM_MSB 31

// Timeout unit: base clock cycles per period step, and reset values
`define RWT_BASE_DIV 512
`define RWT_FWTO_RST 16'h0000
`define RWT_DLY_RST 40'h00_0000_0000

`endif

// ### inc/rwt_pkg.sv
package rwt_pkg;

	typedef struct packed {
		logic auto_reenable;
		logic spectrum_test_mode;
		logic rx_enable;
		logic delayed_rx_enable;
		logic delayed_tx_start;
		logic wait_timeout_enable;
	} rwt_ctrl_t;

	typedef struct packed {
		logic frame_ok;
		logic frame_rejected;
	} rwt_rx_evt_t;

	typedef enum logic [1:0] {
		RWT_RX_IDLE = 2'b00,
		RWT_RX_HUNT = 2'b01
	} rwt_rx_state_t;

endpackage

// ### hdl/rwt_prescaler.sv
`include "rwt_params.svh"

module rwt_prescaler #(
	parameter int DIV = `RWT_BASE_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic base_tick,
	output logic unit_tick
);

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (clear) begin
			cnt <= '0;
		end else if (base_tick) begin
			cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_tick <= 1'b0;
		end else begin
			unit_tick <= !clear && base_tick && (cnt == LAST);
		end
	end

endmodule

// ### hdl/rwt_top.sv
// Added by the designer: the APB interface to the registers.
`include "rwt_params.svh"

// Operation
// - A 40-bit delayed event time is held and its low nine bits are ignored in functional modes.
// - Delayed transmit and delayed receiver turn-on start when their control bit is set and the time matches.
// - In spectrum test mode only bits 31 to 0 of the delayed time are compared.
// - Enabling the receiver with the timeout enabled starts the frame wait countdown.
// - On expiry the receiver turns off, the timeout event is flagged and the counter resets.
// - A good frame flags frame ready and CRC good and, unless automatic re-enable is set, stops the countdown without a timeout.
// - After a timeout the receiver is never re-enabled automatically.
// - Masked-in frame and timeout events raise the interrupt output.
// - Clearing the timeout enable mid-countdown stops it with no timeout event.
// - A rejected frame ends the reception, returns to idle and prevents the timeout.
// - The period is a 16-bit count in units of 512 base clock cycles.
// - With automatic re-enable the countdown restarts whenever the receiver re-enables.
module rwt_top #(
	parameter int BASE_DIV = `RWT_BASE_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic base_tick,
	input wire logic [39:0] sys_time,
	input wire rwt_pkg::rwt_rx_evt_t rx_evt,
	output logic irq,
	output logic tx_start,
	output logic rx_on
);

	logic [39:0] dly_time;
	logic [15:0] fwto;
	rwt_pkg::rwt_ctrl_t ctrl;
	rwt_pkg::rwt_ctrl_t next_ctrl;
	logic [`RWT_EV_W-1:0] status;
	logic [`RWT_EV_W-1:0] next_status;
	logic [`RWT_EV_W-1:0] mask;
	logic [`RWT_EV_W-1:0] ev_set;
	rwt_pkg::rwt_rx_state_t rx_state;
	rwt_pkg::rwt_rx_state_t next_rx_state;
	logic [15:0] to_cnt;
	logic to_run;
	logic next_to_run;
	logic unit_tick;
	logic [31:0] next_rdata;
	logic next_err;

	// Matches only on equality, so a time already passed waits for the next wrap
	function automatic logic dly_due(input logic [39:0] t, input logic [39:0] d,
		input logic pstm);
		if (pstm) begin
			dly_due = (t[`RWT_PSTM_MSB:0] == d[`RWT_PSTM_MSB:0]);
		end else begin
			dly_due = (t[39:`RWT_DLY_IGNORE_BITS] == d[39:`RWT_DLY_IGNORE_BITS]);
		end
	endfunction

	// APB: one wait state, answer in the second access cycle
	wire acc = psel && penable;
	wire done = acc && pready;
	wire wr = done && pwrite;
	wire wr_dly_lo = wr && (paddr == `RWT_ADDR_DLY_LO);
	wire wr_dly_hi = wr && (paddr == `RWT_ADDR_DLY_HI);
	wire wr_fwto = wr && (paddr == `RWT_ADDR_FWTO);
	wire wr_ctrl = wr && (paddr == `RWT_ADDR_CTRL);
	wire wr_status = wr && (paddr == `RWT_ADDR_STATUS);
	wire wr_mask = wr && (paddr == `RWT_ADDR_MASK);

	wire hunting = (rx_state == rwt_pkg::RWT_RX_HUNT);
	wire frame_ok = hunting && rx_evt.frame_ok;
	wire frame_rej = hunting && rx_evt.frame_rejected && !rx_evt.frame_ok;
	wire tx_fire = ctrl.delayed_tx_start && dly_due(sys_time, dly_time, ctrl.spectrum_test_mode);
	wire rx_dly_fire = !hunting && !ctrl.rx_enable && ctrl.delayed_rx_enable
		&& dly_due(sys_time, dly_time, ctrl.spectrum_test_mode);
	wire rx_now = !hunting && ctrl.rx_enable;
	wire rx_restart = frame_ok && ctrl.auto_reenable;
	wire rx_start = rx_now || rx_dly_fire || rx_restart;
	// A frame outcome in the same cycle beats the expiry
	wire to_expire = to_run && ctrl.wait_timeout_enable && (to_cnt == fwto)
		&& !frame_ok && !frame_rej;
	// A restart realigns the prescaler too, else the first unit after it runs short
	wire pre_clear = !to_run || rx_start;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= acc && !pready;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (paddr == `RWT_ADDR_DLY_LO) begin
			next_rdata = dly_time[31:0];
		end else if (paddr == `RWT_ADDR_DLY_HI) begin
			next_rdata = {24'h00_0000, dly_time[39:32]};
		end else if (paddr == `RWT_ADDR_FWTO) begin
			next_rdata = {16'h0000, fwto};
		end else if (paddr == `RWT_ADDR_CTRL) begin
			next_rdata = {26'h000_0000, ctrl};
		end else if (paddr == `RWT_ADDR_STATUS) begin
			next_rdata = {27'h000_0000, status};
		end else if (paddr == `RWT_ADDR_MASK) begin
			next_rdata = {27'h000_0000, mask};
		end else if (paddr == `RWT_ADDR_STATE) begin
			next_rdata = {to_cnt, 13'h0000, to_run, rx_state};
		end else begin
			next_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (acc && !pready) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= next_err;
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_time <= `RWT_DLY_RST;
		end else if (wr_dly_lo) begin
			dly_time[31:0] <= pwdata;
		end else if (wr_dly_hi) begin
			dly_time[39:32] <= pwdata[7:0];
		end
	end

	// Upper half is reserved and dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwto <= `RWT_FWTO_RST;
		end else if (wr_fwto) begin
			fwto <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
		end else if (wr_mask) begin
			mask <= pwdata[`RWT_EV_W-1:0];
		end
	end

	// Command bits clear as their activity begins; a software write in that cycle wins
	always_comb begin
		next_ctrl = ctrl;
		if (tx_fire) begin
			next_ctrl.delayed_tx_start = 1'b0;
		end
		if (rx_dly_fire) begin
			next_ctrl.delayed_rx_enable = 1'b0;
		end
		if (rx_now) begin
			next_ctrl.rx_enable = 1'b0;
		end
		if (wr_ctrl) begin
			next_ctrl = rwt_pkg::rwt_ctrl_t'(pwdata[5:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[`RWT_EV_TIMEOUT] = to_expire;
		ev_set[`RWT_EV_FRAME_READY] = frame_ok;
		ev_set[`RWT_EV_CRC_GOOD] = frame_ok;
		ev_set[`RWT_EV_DLY_TX] = tx_fire;
		ev_set[`RWT_EV_DLY_RX] = rx_dly_fire;
		// Write one to clear; a new event in the same cycle survives
		next_status = (status & ~(wr_status ? pwdata[`RWT_EV_W-1:0] : '0)) | ev_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(status & mask);
		end
	end

	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
			rwt_pkg::RWT_RX_IDLE: begin
				if (rx_start) begin
					next_rx_state = rwt_pkg::RWT_RX_HUNT;
				end
			end
			rwt_pkg::RWT_RX_HUNT: begin
				if (to_expire || frame_rej) begin
					next_rx_state = rwt_pkg::RWT_RX_IDLE;
				end else if (frame_ok && !ctrl.auto_reenable) begin
					next_rx_state = rwt_pkg::RWT_RX_IDLE;
				end
			end
			default: begin
				next_rx_state = rwt_pkg::RWT_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= rwt_pkg::RWT_RX_IDLE;
			rx_on <= 1'b0;
			tx_start <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			rx_on <= (next_rx_state == rwt_pkg::RWT_RX_HUNT);
			tx_start <= tx_fire;
		end
	end

	always_comb begin
		if (rx_start) begin
			next_to_run = ctrl.wait_timeout_enable;
		end else begin
			next_to_run = to_run && ctrl.wait_timeout_enable && !to_expire
				&& !frame_ok && !frame_rej;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_run <= 1'b0;
			to_cnt <= 16'h0000;
		end else begin
			to_run <= next_to_run;
			if (rx_start || !next_to_run) begin
				to_cnt <= 16'h0000;
			end else if (unit_tick) begin
				to_cnt <= to_cnt + 16'h0001;
			end
		end
	end

	rwt_prescaler #(
		.DIV(BASE_DIV)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(pre_clear),
		.base_tick(base_tick),
		.unit_tick(unit_tick)
	);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_START: assert property (rx_start && ctrl.wait_timeout_enable |=> to_run && to_cnt == 16'h0000)
		else $error("countdown did not start with receiver");
	AST_EXPIRE: assert property (to_expire |=> !rx_on && status[`RWT_EV_TIMEOUT] && !to_run)
		else $error("expiry did not stop receiver and flag event");
	AST_GOOD_FRAME: assert property (frame_ok |=> status[`RWT_EV_FRAME_READY]
		&& status[`RWT_EV_CRC_GOOD] && !$rose(status[`RWT_EV_TIMEOUT]))
		else $error("good frame not flagged or timeout raised");
	AST_NO_REENABLE: assert property (to_expire && ctrl.auto_reenable && !wr_ctrl
		|=> !rx_on ##1 !rx_on)
		else $error("receiver came back after timeout");
	AST_WTOE_OFF: assert property ($fell(ctrl.wait_timeout_enable) && to_run
		|=> !to_run && !$rose(status[`RWT_EV_TIMEOUT]))
		else $error("countdown survived enable clear");
	AST_REJECT: assert property (frame_rej |=> rx_state == rwt_pkg::RWT_RX_IDLE && !to_run)
		else $error("rejected frame did not end reception");
	AST_RESTART: assert property (rx_restart && ctrl.wait_timeout_enable
		|=> rx_on && to_run && to_cnt == 16'h0000)
		else $error("countdown not restarted on re-enable");
	AST_COUNT: assert property (to_run && !rx_start && next_to_run && unit_tick
		|=> to_cnt == $past(to_cnt) + 16'h0001)
		else $error("timeout counter missed a unit");
	AST_DLY_TX: assert property (ctrl.delayed_tx_start && !ctrl.spectrum_test_mode
		&& sys_time[39:9] == dly_time[39:9] |=> tx_start)
		else $error("delayed transmit missed its time");
	AST_PSTM: assert property (ctrl.delayed_tx_start && ctrl.spectrum_test_mode
		&& sys_time[31:0] != dly_time[31:0] |=> !tx_start)
		else $error("test mode fired on wrong time");
	AST_IRQ: assert property ((|(status & mask)) |=> irq)
		else $error("masked-in event raised no interrupt");

	COV_TIMEOUT: cover property (rx_start ##[1:1000] to_expire);
	COV_FRAME: cover property (to_run ##[1:1000] frame_ok);
	COV_DLY_TX: cover property (tx_fire);
	COV_DLY_RX: cover property (rx_dly_fire);

endmodule

// ### testbench/rwt_radio_model.sv
// Radio side: base clock ticks, device time and receiver frame events
module rwt_radio_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic send_ok,
	input wire logic send_rej,
	output logic base_tick,
	output logic [39:0] sys_time,
	output rwt_pkg::rwt_rx_evt_t rx_evt
);
	timeunit 1ns;
	timeprecision 1ns;

	// Base tick on every cycle keeps shortened period units exact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_tick <= 1'b0;
			sys_time <= 40'h00_0000_0000;
			rx_evt <= 2'h0;
		end else begin
			base_tick <= 1'b1;
			sys_time <= sys_time + 40'h1;
			rx_evt.frame_ok <= send_ok;
			rx_evt.frame_rejected <= send_rej;
		end
	end
endmodule

// ### testbench/test_rwt_top.sv
module test_rwt_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, tx_start, rx_on, base_tick, last_err;
	logic send_ok = 1'b0;
	logic send_rej = 1'b0;
	logic [39:0] sys_time;
	rwt_pkg::rwt_rx_evt_t rx_evt;
	int n_mismatch = 0;
	int total_checks = 0;

	always #5 pclk = ~pclk;

	rwt_top #(.BASE_DIV(DIV)) i_rwt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .base_tick(base_tick), .sys_time(sys_time),
		.rx_evt(rx_evt), .irq(irq), .tx_start(tx_start), .rx_on(rx_on));
	rwt_radio_model i_rwt_radio_model (.pclk(pclk), .presetn(presetn), .send_ok(send_ok),
		.send_rej(send_rej), .base_tick(base_tick), .sys_time(sys_time), .rx_evt(rx_evt));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	// Bounded wait for rx_on (sel 0) or tx_start (sel 1) to reach v
	task automatic await(input int sel, input logic v, input int lim, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((sel ? tx_start : rx_on) !== v && n < lim);
		if ((sel ? tx_start : rx_on) !== v) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	task automatic pulse(input logic rej);
		@(posedge pclk);
		send_ok <= !rej;
		send_rej <= rej;
		@(posedge pclk);
		send_ok <= 1'b0;
		send_rej <= 1'b0;
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		int n;
		logic [39:0] t;
		logic [31:0] d;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h030, 32'h0);
		rd(12'h028, 32'h0);
		rd(12'h084, 32'h0);
		rd(12'h02c, 32'h0);
		chk(last_err, 32'h1);
		wr(12'h08c, 32'h1f);
		wr(12'h030, 32'h3);
		rd(12'h030, 32'h3);
		// Auto re-enable set, yet a timeout must leave the receiver off
		wr(12'h084, 32'h29);
		await(0, 1'b1, 10, n);
		await(0, 1'b0, 40, n);
		chk(n >= 3 * DIV && n <= 3 * DIV + 3, 32'h1);
		rd(12'h088, 32'h1);
		chk(irq, 32'h1);
		repeat (40) @(posedge pclk);
		chk(rx_on, 32'h0);
		wr(12'h088, 32'h1f);
		rd(12'h088, 32'h0);
		chk(irq, 32'h0);
		wr(12'h084, 32'h9);
		await(0, 1'b1, 10, n);
		pulse(1'b0);
		await(0, 1'b0, 10, n);
		repeat (30) @(posedge pclk);
		rd(12'h088, 32'h6);
		chk(irq, 32'h1);
		wr(12'h088, 32'h1f);
		// Late frame: only a restarted count explains a long wait
		wr(12'h084, 32'h29);
		await(0, 1'b1, 10, n);
		repeat (2 * DIV) @(posedge pclk);
		pulse(1'b0);
		await(0, 1'b0, 60, n);
		chk(n >= 3 * DIV - 2, 32'h1);
		rd(12'h088, 32'h7);
		wr(12'h088, 32'h1f);
		wr(12'h084, 32'h9);
		await(0, 1'b1, 10, n);
		wr(12'h084, 32'h0);
		repeat (30) @(posedge pclk);
		rd(12'h088, 32'h0);
		chk(rx_on, 32'h1);
		pulse(1'b1);
		await(0, 1'b0, 10, n);
		rd(12'h088, 32'h0);
		t = (sys_time + 40'h800) | 40'h1ff;
		wr(12'h028, t[31:0]);
		wr(12'h080, {24'h0, t[39:32]});
		rd(12'h028, t[31:0]);
		wr(12'h084, 32'h2);
		await(1, 1'b1, 3000, n);
		chk(sys_time[39:9], t[39:9]);
		rd(12'h084, 32'h0);
		rd(12'h088, 32'h8);
		wr(12'h088, 32'h1f);
		// High byte set: only a 32-bit compare can still fire
		t = sys_time + 40'h300;
		wr(12'h028, t[31:0]);
		wr(12'h080, 32'hff);
		wr(12'h084, 32'h12);
		await(1, 1'b1, 2000, n);
		d = sys_time[31:0] - t[31:0];
		chk(d < 32'h4, 32'h1);
		t = sys_time + 40'h800;
		wr(12'h028, t[31:0]);
		wr(12'h080, {24'h0, t[39:32]});
		wr(12'h084, 32'h4);
		await(0, 1'b1, 3000, n);
		chk(sys_time[39:9], t[39:9]);
		pulse(1'b1);
		await(0, 1'b0, 10, n);
		rd(12'h088, 32'h18);
		print_verdict();
	end
endmodule
